// ===== rtl/sbs_map.svh
// constants for the supply supervisor and boot select block
// assumes a 10 MHz system clock and comparator inputs from the analog side
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH
`define SBS_CLK_HZ 10000000
`define SBS_START_BOR_US 3300
`define SBS_START_NOBOR_US 1000
`define SBS_START_BOR_CYC ((`SBS_START_BOR_US * (`SBS_CLK_HZ / 1000000)))
`define SBS_START_NOBOR_CYC ((`SBS_START_NOBOR_US * (`SBS_CLK_HZ / 1000000)))
`define SBS_LOAD_CYC 16'h0008
`define SBS_BOR_LVL_RST 3'h0
`define SBS_BOR_LVL_MAX 3'h4
`define SBS_PVD_LVL_MAX 3'h6
`endif

// ===== rtl/sbs_pkg.sv
// types for the supply supervisor and boot select block
// assumes sbs_map.svh constants are used alongside
package sbs_pkg;
  typedef enum logic [1:0] {
    SBS_BOOT_FLASH,
    SBS_BOOT_SYSTEM,
    SBS_BOOT_RAM
  } sbs_boot_type;
  typedef enum logic [2:0] {
    SBS_PM_RUN,
    SBS_PM_SLEEP,
    SBS_PM_LP_RUN,
    SBS_PM_LP_SLEEP,
    SBS_PM_STOP,
    SBS_PM_STANDBY
  } sbs_pmode_type;
  typedef enum logic [1:0] {
    SBS_REG_MAIN,
    SBS_REG_LOW_POWER,
    SBS_REG_POWER_DOWN
  } sbs_reg_type;
  typedef enum {
    SBS_ST_HOLD,
    SBS_ST_LOAD,
    SBS_ST_START,
    SBS_ST_RUN
  } sbs_state_type;
endpackage

// ===== rtl/sbs_supervisor.sv
// supply supervisor, option load, boot select, detector, regulator mode
// the sequencer holds reset until the supply is good, reads the option
// bits, waits out the start-up time and then releases the device
// a supply drop at any point restarts the whole sequence
// the detector is blind while the device is held in reset, except in the first reset cycle after leaving run
// assumes analog comparators and pins are asynchronous to clk_sys_in
// assumes option and software inputs are already on clk_sys_in
// assumes power_mode_in is steady between system clock edges
// assumes a detector level change is made with the detector disabled
`include "sbs_map.svh"
module sbs_supervisor #(
  parameter logic [15:0] START_BOR_CYC = 16'(`SBS_START_BOR_CYC),
  parameter logic [15:0] START_NOBOR_CYC = 16'(`SBS_START_NOBOR_CYC)
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic external_reset_pin_in,
  // analog comparators, asynchronous
  input wire logic por_ok_in,
  input wire logic [4:0] bor_above_in,
  input wire logic [6:0] pvd_above_in,
  // pins, asynchronous
  input wire logic ext_reset_n_in,
  input wire logic boot_strap_pin_in,
  // part variant and option bytes
  input wire logic bor_at_power_on_in,
  input wire logic opt_bor_disable_in,
  input wire logic [2:0] opt_bor_level_in,
  input wire logic boot_option_bit_a_in,
  input wire logic boot_option_bit_b_in,
  input wire logic boot_source_select_bit_in,
  // flash state and software controls
  input wire logic flash_empty_in,
  input wire logic pvd_enable_in,
  input wire logic [2:0] pvd_level_in,
  input wire logic pvd_irq_fall_en_in,
  input wire logic pvd_irq_rise_en_in,
  input wire logic pvd_irq_clear_in,
  input wire logic vref_off_in_stop_in,
  // power mode from the mode controller
  input wire sbs_pkg::sbs_pmode_type power_mode_in,
  // sequencer and boot results
  output logic sys_reset_n_out,
  output logic opt_load_out,
  output logic brownout_reset_en_out,
  output logic [2:0] brownout_level_out,
  output sbs_pkg::sbs_boot_type boot_source_out,
  // detector
  output logic supply_level_above_out,
  output logic pvd_irq_out,
  // reference and regulator
  output logic internal_reference_voltage_en_out,
  output sbs_pkg::sbs_reg_type regulator_mode_out,
  output logic standby_keep_out
);

  ////////////////////////////////////////////////////////////////////////
  // reset release synchroniser
  // reset asserts at once but leaves in step with the clock, so no
  // flop sees the release close to its own edge
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk_sys_in or negedge external_reset_pin_in) begin
    if (!external_reset_pin_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every asynchronous input
  // comparator, pin and strap levels may move at any time; only the
  // second rank is read, so a metastable first rank never reaches logic
  // the bus order below must match the split into named fields
  localparam int SW = 15;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic [SW-1:0] raw;
  assign raw = {
    pvd_above_in,
    bor_above_in,
    por_ok_in,
    ext_reset_n_in,
    boot_strap_pin_in
  };
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end
  logic [6:0] pvd_s;
  logic [4:0] bor_s;
  logic por_s;
  logic external_reset_pin_pin_s;
  logic strap_s;
  assign {
    pvd_s,
    bor_s,
    por_s,
    external_reset_pin_pin_s,
    strap_s
  } = sync_q;

  ////////////////////////////////////////////////////////////////////////
  // module state
  typedef struct packed {
    // sequencer
    sbs_pkg::sbs_state_type st;
    logic [15:0] cnt;
    // options latched at the end of the load
    logic bor_en;
    logic [2:0] bor_lvl;
    logic boot_a;
    logic boot_b;
    logic boot_sel;
    // boot strap capture and result
    logic strap;
    logic external_reset_pin_prev;
    sbs_pkg::sbs_boot_type boot;
    // detector
    logic pvd_prev;
    logic pvd_armed;
    logic irq;
  } sbs_st_type;
  sbs_st_type s_q;
  sbs_st_type s_d;

  // selected comparator results
  // level codes above the top threshold are clamped to it
  // brownout only counts once enabled; the power-on check always does
  // the detector level is applied without a synchroniser
  logic bor_ok;
  logic supply_ok;
  logic pvd_now;
  logic [2:0] bor_idx;
  logic [2:0] pvd_idx;
  always_comb begin
    bor_idx = (s_q.bor_lvl > `SBS_BOR_LVL_MAX) ? `SBS_BOR_LVL_MAX
      : s_q.bor_lvl;
    pvd_idx = (pvd_level_in > `SBS_PVD_LVL_MAX) ? `SBS_PVD_LVL_MAX
      : pvd_level_in;
    bor_ok = !s_q.bor_en || bor_s[bor_idx];
    supply_ok = por_s && bor_ok;
    pvd_now = pvd_s[pvd_idx];
  end

  // boot decode: fixed truth table
  // boot_strap_pin is option bit a inverted when the select bit is set
  // empty sel strap a b  target
  //   1    x    x   x x  system
  //   0    1    x   1 x  flash
  //   0    0    0   x x  flash
  //   0    1    x   0 1  system
  //   0    1    x   0 0  ram
  //   0    0    1   x 1  system
  //   0    0    1   x 0  ram
  function automatic sbs_pkg::sbs_boot_type boot_dec(
    input logic empty, input logic sel, input logic strap,
    input logic a, input logic b);
    logic boot_strap_pin;
    boot_strap_pin = sel ? !a : strap;
    if (empty) begin
      boot_dec = sbs_pkg::SBS_BOOT_SYSTEM;
    end else if (!boot_strap_pin) begin
      boot_dec = sbs_pkg::SBS_BOOT_FLASH;
    end else if (b) begin
      boot_dec = sbs_pkg::SBS_BOOT_SYSTEM;
    end else begin
      boot_dec = sbs_pkg::SBS_BOOT_RAM;
    end
  endfunction

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.external_reset_pin_prev = external_reset_pin_pin_s;
    // strap captured on rising edge of external reset pin
    // later pin changes leave the captured value alone
    if (external_reset_pin_pin_s && !s_q.external_reset_pin_prev) begin
      s_d.strap = strap_s;
    end
    unique case (s_q.st)
      // wait in reset until the supply is good
      sbs_pkg::SBS_ST_HOLD: begin
        s_d.cnt = 16'h0000;
        if (supply_ok) begin
          s_d.st = sbs_pkg::SBS_ST_LOAD;
        end
      end
      // option bits settle for a fixed count, then are latched
      sbs_pkg::SBS_ST_LOAD: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == `SBS_LOAD_CYC - 16'h0001) begin
          s_d.bor_en = !opt_bor_disable_in;
          s_d.bor_lvl = (opt_bor_level_in > `SBS_BOR_LVL_MAX) ?
            `SBS_BOR_LVL_MAX : opt_bor_level_in;
          s_d.boot_a = boot_option_bit_a_in;
          s_d.boot_b = boot_option_bit_b_in;
          s_d.boot_sel = boot_source_select_bit_in;
          s_d.cnt = `SBS_LOAD_CYC;
          s_d.st = sbs_pkg::SBS_ST_START;
        end
      end
      // start-up delay, longer when brownout is active at power-up
      sbs_pkg::SBS_ST_START: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt >= (bor_at_power_on_in ? START_BOR_CYC
            : START_NOBOR_CYC)) begin
          s_d.boot = boot_dec(flash_empty_in, s_q.boot_sel, s_q.strap,
            s_q.boot_a, s_q.boot_b);
          s_d.st = sbs_pkg::SBS_ST_RUN;
        end
      end
      // released: counter parked, options and boot source held
      sbs_pkg::SBS_ST_RUN: begin
        s_d.cnt = s_q.cnt;
      end
    endcase
    // supply loss returns to hold from any state
    // the next rise runs the load and start-up again from the beginning
    if (!supply_ok) begin
      s_d.st = sbs_pkg::SBS_ST_HOLD;
      s_d.cnt = 16'h0000;
    end
    // detector: armed one cycle after enable, edge flags
    // the first cycle after enable only loads the previous level, so a
    // stale level from before enable cannot look like a crossing
    // clear and enable-low drop the flag; a new crossing wins over clear, but not over enable-low
    s_d.pvd_prev = pvd_now;
    s_d.pvd_armed = pvd_enable_in && s_q.st == sbs_pkg::SBS_ST_RUN;
    if (pvd_irq_clear_in || !pvd_enable_in) begin
      s_d.irq = 1'b0;
    end
    if (s_q.pvd_armed && pvd_enable_in) begin
      if ((pvd_irq_fall_en_in && s_q.pvd_prev && !pvd_now) ||
          (pvd_irq_rise_en_in && !s_q.pvd_prev && pvd_now)) begin
        s_d.irq = 1'b1;
      end
    end
  end

  // state register
  // the sequencer, option, boot and detector state is one word, loaded with its reset values by the local reset
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{
        st: sbs_pkg::SBS_ST_HOLD,
        cnt: 16'h0000,
        bor_en: 1'b1,
        bor_lvl: `SBS_BOR_LVL_RST,
        boot_a: 1'b1,
        boot_b: 1'b1,
        boot_sel: 1'b1,
        strap: 1'b0,
        external_reset_pin_prev: 1'b0,
        boot: sbs_pkg::SBS_BOOT_FLASH,
        pvd_prev: 1'b0,
        pvd_armed: 1'b0,
        irq: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // reset and boot outputs come straight from the state register
  // the detector output reads low until the detector is armed
  // regulator and reference follow the power mode with no delay
  // codes 6 and 7 are unused; they fall back to the main regulator
  always_comb begin
    sys_reset_n_out = (s_q.st == sbs_pkg::SBS_ST_RUN);
    opt_load_out = (s_q.st == sbs_pkg::SBS_ST_LOAD);
    brownout_reset_en_out = s_q.bor_en;
    brownout_level_out = s_q.bor_lvl;
    boot_source_out = s_q.boot;
    supply_level_above_out = s_q.pvd_armed && s_q.pvd_prev;
    pvd_irq_out = s_q.irq;
    internal_reference_voltage_en_out = !(vref_off_in_stop_in &&
      power_mode_in == sbs_pkg::SBS_PM_STOP);
    standby_keep_out = (power_mode_in == sbs_pkg::SBS_PM_STANDBY);
    unique case (power_mode_in)
      sbs_pkg::SBS_PM_RUN, sbs_pkg::SBS_PM_SLEEP:
        regulator_mode_out = sbs_pkg::SBS_REG_MAIN;
      sbs_pkg::SBS_PM_LP_RUN, sbs_pkg::SBS_PM_LP_SLEEP,
        sbs_pkg::SBS_PM_STOP:
        regulator_mode_out = sbs_pkg::SBS_REG_LOW_POWER;
      sbs_pkg::SBS_PM_STANDBY:
        regulator_mode_out = sbs_pkg::SBS_REG_POWER_DOWN;
      default:
        regulator_mode_out = sbs_pkg::SBS_REG_MAIN;
    endcase
  end

endmodule

// ===== tb/sbs_supply_model.sv
// supply comparators standing in for the analog side
// assumes the bench drives the supply level in millivolts
module sbs_supply_model (
  input wire logic [15:0] vdd_mv_in,
  output logic por_ok_out,
  output logic [4:0] bor_above_out,
  output logic [6:0] pvd_above_out
);
  // comparator outputs follow the supply with no delay
  always_comb begin
    por_ok_out = vdd_mv_in >= 16'h0672;
    for (int i = 0; i < 5; i++)
      bor_above_out[i] = vdd_mv_in >= 16'h0708 + 16'(i) * 16'h012C;
    for (int i = 0; i < 7; i++)
      pvd_above_out[i] = vdd_mv_in >= 16'h073A + 16'(i) * 16'h00C8;
  end
endmodule

// ===== tb/sbs_supervisor_sva.sv
// port checker for the supply supervisor
// assumes binding onto sbs_supervisor, one clock domain
module sbs_supervisor_sva (
  input wire logic clk_sys_in,
  input wire logic external_reset_pin_in,
  input wire logic por_ok_in,
  input wire logic pvd_enable_in,
  input wire logic vref_off_in_stop_in,
  input wire sbs_pkg::sbs_pmode_type power_mode_in,
  input wire logic sys_reset_n_out,
  input wire logic opt_load_out,
  input wire logic pvd_irq_out,
  input wire logic internal_reference_voltage_en_out,
  input wire logic standby_keep_out,
  input wire sbs_pkg::sbs_reg_type regulator_mode_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!external_reset_pin_in);
  // regulator mode, standby keep and reference follow the power mode
  run_main_a: assert property (power_mode_in == sbs_pkg::SBS_PM_RUN
    |-> regulator_mode_out == sbs_pkg::SBS_REG_MAIN) else $error("main");
  low_power_a: assert property (power_mode_in inside {3'h2, 3'h3, 3'h4}
    |-> regulator_mode_out == sbs_pkg::SBS_REG_LOW_POWER) else $error("lp");
  standby_down_a: assert property (power_mode_in == 3'h5
    |-> regulator_mode_out == 2'h2 && standby_keep_out) else $error("down");
  vref_stop_a: assert property (vref_off_in_stop_in &&
    power_mode_in == 3'h4 |-> !internal_reference_voltage_en_out)
    else $error("vref");
  // reset and start-up sequence, and detector flag off when disabled
  hold_low_a: assert property (!por_ok_in [*5] |-> !sys_reset_n_out)
    else $error("hold");
  load_len_a: assert property ($rose(opt_load_out)
    |-> opt_load_out [*8] ##1 !opt_load_out) else $error("load");
  start_wait_a: assert property ($fell(opt_load_out)
    |-> !sys_reset_n_out [*8]) else $error("start");
  pvd_off_a: assert property (!pvd_enable_in [*2] |-> !pvd_irq_out)
    else $error("pvd");
endmodule
bind sbs_supervisor sbs_supervisor_sva sbs_supervisor_sva_inst (.*);

// ===== tb/supply_supervisor_boot_select_bench.sv
// self-checking bench for the supply supervisor and boot select
// assumes the design, supply model and checker are compiled first
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module supply_supervisor_boot_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, external_reset_pin_in = 0, ext_reset_n_in = 1;
  logic boot_strap_pin_in = 0, bor_at_power_on_in = 0;
  logic opt_bor_disable_in = 0, flash_empty_in = 0;
  logic [2:0] opt_bor_level_in = 0, pvd_level_in = 0;
  logic boot_option_bit_a_in = 0, boot_option_bit_b_in = 0;
  logic boot_source_select_bit_in = 0, pvd_enable_in = 0;
  logic pvd_irq_fall_en_in = 0, pvd_irq_rise_en_in = 0;
  logic pvd_irq_clear_in = 0, vref_off_in_stop_in = 0;
  sbs_pkg::sbs_pmode_type power_mode_in = sbs_pkg::SBS_PM_RUN;
  logic por_ok_in, sys_reset_n_out, opt_load_out, brownout_reset_en_out;
  logic [4:0] bor_above_in;
  logic [6:0] pvd_above_in;
  logic supply_level_above_out, pvd_irq_out, standby_keep_out;
  logic internal_reference_voltage_en_out;
  logic [2:0] brownout_level_out;
  sbs_pkg::sbs_boot_type boot_source_out;
  sbs_pkg::sbs_reg_type regulator_mode_out;
  logic [15:0] vdd = 0;
  logic [31:0] seed = 32'h56AA;
  logic [13:0] expq[$];
  logic [13:0] exp_v;
  logic rst_prev = 1'b0;
  logic [7:0] st_cyc = 8'h00;
  // short start-up counts keep the run brief; both exceed the load
  localparam logic [15:0] START_BOR = 16'h0014;
  localparam logic [15:0] START_NOBOR = 16'h0010;
  int errors = 0, compares = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  sbs_supervisor #(.START_BOR_CYC(START_BOR), .START_NOBOR_CYC(START_NOBOR))
    sbs_supervisor_inst (.*);
  sbs_supply_model sbs_supply_model_inst (.vdd_mv_in(vdd),
    .por_ok_out(por_ok_in), .bor_above_out(bor_above_in),
    .pvd_above_out(pvd_above_in));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // v = empty, select bit, strap, option a, option b
  function sbs_pkg::sbs_boot_type bexp(logic [4:0] v);
    logic b0;
    b0 = v[3] ? !v[1] : v[2];
    if (v[4] || (b0 && v[0])) return sbs_pkg::SBS_BOOT_SYSTEM;
    return b0 ? sbs_pkg::SBS_BOOT_RAM : sbs_pkg::SBS_BOOT_FLASH;
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bounded wait for the release (0) or the detector flag (1)
  task automatic wait_up(input bit on_irq);
    for (int k = 0; k < 200 && (on_irq ? pvd_irq_out : sys_reset_n_out)
        !== 1'b1; k++) cyc(1);
    if ((on_irq ? pvd_irq_out : sys_reset_n_out) !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask
  // start-up length, loaded options and boot source when reset lifts
  always @(posedge clk_sys_in) begin
    if (opt_load_out)
      st_cyc <= 8'h00;
    else if (!sys_reset_n_out)
      st_cyc <= st_cyc + 8'h01;
    rst_prev <= sys_reset_n_out;
    if (sys_reset_n_out && !rst_prev && expq.size() > 0) begin
      exp_v = expq.pop_front();
      `CHK({st_cyc, boot_source_out, brownout_reset_en_out,
        brownout_level_out}, exp_v)
    end
  end
  initial begin
    cyc(6);
    external_reset_pin_in = 1;
    // boot table over every pin and option combination
    for (int i = 0; i < 32; i++) begin
      logic [31:0] r;
      r = rnd();
      vdd = 16'h0000;
      ext_reset_n_in = 0;
      cyc(6);
      `CHK(sys_reset_n_out, 1'b0)
      {flash_empty_in, boot_source_select_bit_in, boot_strap_pin_in,
        boot_option_bit_a_in, boot_option_bit_b_in} = i[4:0];
      opt_bor_level_in = r[2:0];
      opt_bor_disable_in = r[3] | (i == 31);
      bor_at_power_on_in = r[4];
      ext_reset_n_in = 1;
      cyc(4);
      boot_strap_pin_in = ~boot_strap_pin_in; // later pin changes ignored
      // start state counts from the end of the load up to its limit
      expq.push_back({(bor_at_power_on_in ? START_BOR[7:0] : START_NOBOR[7:0])
        - 8'h07, bexp(i[4:0]), ~opt_bor_disable_in,
        opt_bor_level_in > 3'h4 ? 3'h4 : opt_bor_level_in});
      vdd = 16'h0E10;
      wait_up(1'b0);
      cyc(2);
    end
    // detector levels: rise, clear, then fall when selected
    for (int k = 0; k < 7; k++) begin
      pvd_level_in = k[2:0];
      vdd = 16'h0708 + 16'(k) * 16'h00C8;
      pvd_irq_fall_en_in = k[0];
      pvd_irq_rise_en_in = 1;
      pvd_enable_in = 1;
      cyc(6);
      `CHK(pvd_irq_out, 1'b0)
      vdd += 16'h0064;
      wait_up(1'b1);
      `CHK(supply_level_above_out, 1'b1)
      pvd_irq_clear_in = 1;
      cyc(1);
      pvd_irq_clear_in = 0;
      vdd -= 16'h0064;
      cyc(8);
      `CHK(pvd_irq_out, k[0])
      pvd_enable_in = 0;
      cyc(2);
      `CHK(pvd_irq_out, 1'b0)
    end
    // regulator and reference per power mode
    for (int m = 0; m < 6; m++) begin
      power_mode_in = sbs_pkg::sbs_pmode_type'(m);
      vref_off_in_stop_in = 1'(rnd());
      cyc(1);
      `CHK(regulator_mode_out, m == 5 ? sbs_pkg::SBS_REG_POWER_DOWN :
        m > 1 ? sbs_pkg::SBS_REG_LOW_POWER : sbs_pkg::SBS_REG_MAIN)
      `CHK(standby_keep_out, m == 5)
      `CHK(internal_reference_voltage_en_out,
        !(m == 4 && vref_off_in_stop_in))
    end
    `CHK(expq.size(), 0)
    complete_run();
  end
endmodule
